// file: hdl/scd_pkg.sv
// Behaviour
// RL1 - cmd 00, bit7 clear: status then register
// RL2 - cmd 00, bit7 set: status then device info
// RL3 - cmd 01 writes data; answer status, extended status
// RL4 - cmd 11 returns status then low/high flags
// RL5 - host sends bit 8 one on reads
// RL6 - parity concerns write frames only
// RL7 - parity counts bits 15-9 and 7-0
// RL8 - host makes overall parity odd
// RL9 - parity checked only when enable bit set
// RL10 - host sends bit 8 zero without parity
// RL11 - monitor register fields; bits 2-0 zero
// RL12 - source select: off, then seven sources
// RL13 - bit 4 enables internal ground resistor
// RL14 - bit 3 attenuates, only for io sources
// RL15 - monitor clears: reset, supply off, not normal
// RL16 - access with supply off ignored, cleared
// RL17 - bad parity write is discarded
// RL18 - sixteen bits, msb first, act after all
package scd_pkg;
    // command codes in frame bits 15..14
    localparam logic [1:0] CMD_READ = 2'h0;
    localparam logic [1:0] CMD_WRITE = 2'h1;
    localparam logic [1:0] CMD_RSVD = 2'h2;
    localparam logic [1:0] CMD_FLAG = 2'h3;
    // register addresses and layout
    localparam logic [4:0] ADDR_MONITOR = 5'h00;
    localparam logic [7:0] MON_RESET = 8'h00;
    localparam logic [7:0] MON_WRITE_MASK = 8'hf8;
    localparam int MON_SRC_HI = 7;
    localparam int MON_SRC_LO = 5;
    localparam int MON_RES_BIT = 4;
    localparam int MON_ATT_BIT = 3;
    localparam logic [2:0] SRC_OFF = 3'h0;
    localparam logic [2:0] SRC_IO0 = 3'h4;
    localparam logic [2:0] SRC_IO1 = 3'h5;
    localparam int NUM_SOURCES = 7;
    // frame counting
    localparam logic [4:0] BITS_FRAME = 5'h10;
    localparam logic [4:0] BITS_FIRST_BYTE = 5'h08;
    localparam logic [4:0] BITS_ADDR_DONE = 5'h07;
    localparam logic [4:0] BITS_SAT = 5'h1f;
    localparam logic [7:0] ANSWER_NONE = 8'h00;

    // one received frame, msb first
    typedef struct packed {
        logic [1:0] cmd;
        logic [4:0] addr;
        logic pn;
        logic [7:0] data;
    } scd_frame_t;

    // the three sampled spi pins
    typedef struct packed {
        logic sclk;
        logic cs_n;
        logic mosi;
    } scd_pins_t;

    typedef enum logic [0:0] {
        ST_IDLE = 1'b0,
        ST_ACTIVE = 1'b1
    } scd_state_t;
endpackage : scd_pkg

// file: hdl/scd_spi_decoder.sv
`timescale 1ns/10ps
`default_nettype none
// spi slave command decoder with analog monitor select register
module scd_spi_decoder
    import scd_pkg::*;
(
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic spi_sclk,
    input wire logic spi_cs_n,
    input wire logic spi_mosi,
    output logic spi_miso,
    output logic spi_miso_oe,
    input wire logic [7:0] fixed_status,
    input wire logic [7:0] ext_status,
    input wire logic [7:0] device_info,
    input wire logic [7:0] flags_low,
    input wire logic [7:0] flags_high,
    input wire logic parity_check_en,
    input wire logic can_supply_on,
    input wire logic normal_mode,
    output logic [4:0] frame_addr,
    output logic [2:0] monitor_source_sel,
    output logic [NUM_SOURCES-1:0] monitor_route,
    output logic internal_load_resistor_en,
    output logic monitor_attenuate
);
    scd_pins_t pins_raw; // pins as they arrive
    scd_pins_t pins_s; // pins after two flops

    assign pins_raw = '{sclk: spi_sclk, cs_n: spi_cs_n, mosi: spi_mosi};

    // every pin crosses two flops before anything looks at it
    // sclk parks low and cs_n high, so the edge history starts at idle
    scd_sync #(
        .WIDTH(3),
        .RST_VAL(scd_pins_t'{sclk: 1'b0, cs_n: 1'b1, mosi: 1'b0})
    ) u_sync (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .async_in(pins_raw),
        .sync_out(pins_s)
    );

    // ---------------- edge detection ----------------
    logic sclk_q; // previous synchronised sclk
    logic cs_n_q; // previous synchronised cs_n
    logic fall_d; // sclk fall, one cycle late so mosi has settled
    logic sclk_rise;
    logic sclk_fall;
    logic cs_fall;
    logic cs_rise;

    assign sclk_rise = pins_s.sclk & ~sclk_q;
    assign sclk_fall = ~pins_s.sclk & sclk_q;
    assign cs_fall = ~pins_s.cs_n & cs_n_q;
    assign cs_rise = pins_s.cs_n & ~cs_n_q;

    // history flops for edge finding
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            sclk_q <= 1'b0;
            cs_n_q <= 1'b1;
            fall_d <= 1'b0;
        end else begin
            sclk_q <= pins_s.sclk;
            cs_n_q <= pins_s.cs_n;
            fall_d <= sclk_fall;
        end
    end

    // ---------------- frame shifter ----------------
    scd_state_t state, next_state;
    logic [15:0] rx, next_rx; // received bits, newest at bit 0
    logic [4:0] bit_cnt, next_bit_cnt; // rising edges seen this frame
    logic [7:0] tx, next_tx; // bits still to send in this byte
    logic next_miso;
    logic next_miso_oe;
    logic [4:0] next_frame_addr;
    logic frame_done, next_frame_done; // one-cycle pulse, full frame in
    logic [7:0] mon_reg, next_mon_reg; // analog monitor select register
    logic [7:0] answer; // second reply byte
    scd_frame_t head; // first byte as seen at the answer point
    scd_frame_t frame; // complete frame at cs rise

    assign head = scd_frame_t'({rx[7:0], 8'h00});
    assign frame = scd_frame_t'(rx);

    // answer byte; bit 7 of mosi is live on the line at this point
    always_comb begin
        answer = ANSWER_NONE;
        case (head.cmd)
            CMD_READ: begin
                if (pins_s.mosi) begin
                    answer = device_info; // RL2
                end else if (head.addr == ADDR_MONITOR) begin
                    answer = mon_reg; // RL1
                end else begin
                    answer = ANSWER_NONE; // other registers live elsewhere
                end
            end
            CMD_WRITE: answer = ext_status; // RL3
            CMD_FLAG: answer = pins_s.mosi ? flags_high : flags_low; // RL4
            default: answer = ANSWER_NONE; // reserved code
        endcase
    end

    // shifter next state: sample on rise, drive on fall, msb first
    always_comb begin
        next_state = state;
        next_rx = rx;
        next_bit_cnt = bit_cnt;
        next_tx = tx;
        next_miso = spi_miso;
        next_frame_addr = frame_addr;
        next_frame_done = 1'b0;
        case (state)
            ST_IDLE: begin
                if (cs_fall) begin
                    // fixed status is presented before the first clock
                    next_state = ST_ACTIVE;
                    next_bit_cnt = '0;
                    next_rx = '0;
                    next_miso = fixed_status[7];
                    next_tx = {fixed_status[6:0], 1'b0};
                end
            end
            ST_ACTIVE: begin
                if (cs_rise) begin
                    next_state = ST_IDLE;
                    // act only on exactly sixteen bits
                    next_frame_done = (bit_cnt == BITS_FRAME); // RL18
                end else begin
                    if (sclk_rise && bit_cnt != BITS_SAT) begin
                        next_rx = {rx[14:0], pins_s.mosi}; // RL18
                        next_bit_cnt = bit_cnt + 5'h01;
                        // address is known once bits 15..9 are in
                        if (next_bit_cnt == BITS_ADDR_DONE) begin
                            next_frame_addr = next_rx[4:0];
                        end
                    end
                    if (fall_d) begin
                        if (bit_cnt == BITS_FIRST_BYTE) begin
                            next_miso = answer[7];
                            next_tx = {answer[6:0], 1'b0};
                        end else if (bit_cnt < BITS_FRAME) begin
                            next_miso = tx[7];
                            next_tx = {tx[6:0], 1'b0};
                        end
                    end
                end
            end
            default: next_state = ST_IDLE;
        endcase
        next_miso_oe = (next_state == ST_ACTIVE);
    end

    // shifter registers
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            state <= ST_IDLE;
            rx <= '0;
            bit_cnt <= '0;
            tx <= '0;
            spi_miso <= 1'b0;
            spi_miso_oe <= 1'b0;
            frame_addr <= '0;
            frame_done <= 1'b0;
        end else begin
            state <= next_state;
            rx <= next_rx;
            bit_cnt <= next_bit_cnt;
            tx <= next_tx;
            spi_miso <= next_miso;
            spi_miso_oe <= next_miso_oe;
            frame_addr <= next_frame_addr;
            frame_done <= next_frame_done;
        end
    end

    // ---------------- monitor register ----------------
    logic parity_ok; // write frame passes the optional check
    logic mon_write; // a full write frame to the monitor register, before the parity and supply checks

    // odd overall parity over all sixteen bits equals the stated rule
    assign parity_ok = ~parity_check_en | (^rx); // RL7 RL9
    assign mon_write = frame_done && frame.cmd == CMD_WRITE
                       && frame.addr == ADDR_MONITOR; // RL6

    // next register value; supply off or mode change wins over a write
    always_comb begin
        next_mon_reg = mon_reg;
        if (!can_supply_on || !normal_mode) begin
            next_mon_reg = MON_RESET; // RL15 RL16
        end else if (mon_write && parity_ok) begin
            next_mon_reg = frame.data & MON_WRITE_MASK; // RL3 RL11
        end else if (mon_write) begin
            next_mon_reg = mon_reg; // RL17
        end
    end

    // register plus decoded analog controls
    logic [2:0] src; // current source select
    logic [NUM_SOURCES-1:0] next_route;

    assign src = mon_reg[MON_SRC_HI:MON_SRC_LO];

    // one route line per source code 1..7; code 0 drives none
    genvar g;
    generate
        for (g = 0; g < NUM_SOURCES; g++) begin : g_route
            assign next_route[g] = (src == 3'(g + 1)); // RL12
        end
    endgenerate

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            mon_reg <= MON_RESET; // RL15
            monitor_source_sel <= SRC_OFF;
            monitor_route <= '0;
            internal_load_resistor_en <= 1'b0;
            monitor_attenuate <= 1'b0;
        end else begin
            mon_reg <= next_mon_reg;
            monitor_source_sel <= src;
            monitor_route <= next_route;
            internal_load_resistor_en <= mon_reg[MON_RES_BIT]; // RL13
            // attenuation only means something on the io inputs
            monitor_attenuate <= mon_reg[MON_ATT_BIT]
                                 && (src == SRC_IO0 || src == SRC_IO1); // RL14
        end
    end

    // ---------------- checks ----------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    logic answer_pt; // cycle where the second byte is loaded
    assign answer_pt = state == ST_ACTIVE && !cs_rise && fall_d
                       && bit_cnt == BITS_FIRST_BYTE;

    chk_readback_byte: assert property ( // RL1
        answer_pt && head.cmd == CMD_READ && !pins_s.mosi
        && head.addr == ADDR_MONITOR |=> spi_miso == $past(mon_reg[7]))
        else $error("read-back did not start with register bit 7");
    chk_info_byte: assert property ( // RL2
        answer_pt && head.cmd == CMD_READ && pins_s.mosi
        |=> spi_miso == $past(device_info[7]))
        else $error("device info byte not returned");
    chk_write_status: assert property ( // RL3
        answer_pt && head.cmd == CMD_WRITE |=> spi_miso == $past(ext_status[7]))
        else $error("write frame did not return extended status");
    chk_flag_byte: assert property ( // RL4
        answer_pt && head.cmd == CMD_FLAG
        |=> spi_miso == ($past(pins_s.mosi) ? $past(flags_high[7]) : $past(flags_low[7])))
        else $error("wrong flag byte returned");
    chk_write_lands: assert property ( // RL9
        mon_write && !parity_check_en && can_supply_on && normal_mode
        |=> mon_reg == ($past(frame.data) & MON_WRITE_MASK))
        else $error("write without parity check did not land");
    chk_parity_drop: assert property ( // RL17
        mon_write && parity_check_en && !(^rx) && can_supply_on && normal_mode
        |=> $stable(mon_reg))
        else $error("write with bad parity changed the register");
    chk_short_frame: assert property ( // RL18
        state == ST_ACTIVE && cs_rise && bit_cnt != BITS_FRAME
        && can_supply_on && normal_mode |=> ##1 $stable(mon_reg))
        else $error("short frame changed the register");
    chk_supply_off: assert property ( // RL15
        !can_supply_on || !normal_mode |=> mon_reg == MON_RESET ##1 monitor_route == '0)
        else $error("monitor not cleared with supply off or mode change");
    chk_low_zero: assert property ( // RL11
        mon_reg[2:0] == 3'h0)
        else $error("monitor low bits not zero");
    chk_atten_gate: assert property ( // RL14
        monitor_attenuate |-> monitor_source_sel == SRC_IO0 || monitor_source_sel == SRC_IO1)
        else $error("attenuation active on a non-io source");
    chk_route_off: assert property ( // RL12
        ##1 ((monitor_route == '0) == ($past(src) == SRC_OFF)))
        else $error("route lines disagree with source select");

    // oe drops whenever select is seen released
    chk_oe_release: assert property ( // RL18
        pins_s.cs_n |=> !spi_miso_oe)
        else $error("miso driven while deselected");
    // an accepted frame always counted sixteen rising edges
    chk_frame_len: assert property ( // RL18
        frame_done |-> bit_cnt == BITS_FRAME)
        else $error("frame acted on without sixteen bits");
    // once selected, reply bits only move at a falling clock, never mid-bit
    chk_miso_hold: assert property ( // RL18
        state == ST_ACTIVE && !fall_d |=> $stable(spi_miso))
        else $error("reply bit changed outside a falling clock");
    // address is latched as the seventh bit comes in
    chk_addr_capture: assert property ( // RL4
        state == ST_ACTIVE && !cs_rise && sclk_rise
        && bit_cnt == BITS_ADDR_DONE - 5'h01
        |=> frame_addr == $past({rx[3:0], pins_s.mosi}))
        else $error("frame address not captured at bit seven");

    // main traffic kinds seen at least once
    cov_mon_write: cover property (mon_write && parity_ok && can_supply_on && normal_mode);
    cov_flag_read: cover property (answer_pt && head.cmd == CMD_FLAG);
    cov_parity_bad: cover property (mon_write && parity_check_en && !(^rx));
    cov_cut_frame: cover property (state == ST_ACTIVE && cs_rise && bit_cnt != BITS_FRAME);
    cov_info_read: cover property (answer_pt && head.cmd == CMD_READ && pins_s.mosi);
endmodule : scd_spi_decoder
`default_nettype wire

// file: hdl/scd_sync.sv
`timescale 1ns/10ps
`default_nettype none
// two-stage synchroniser, one stage pair per bit
module scd_sync #(
    parameter int WIDTH = 3,
    parameter logic [WIDTH-1:0] RST_VAL = '1 // idle level of each pin
) (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta; // first stage, read only by second stage

    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            // reset to each pin's idle level so no edge is faked at release
            always_ff @(posedge sys_clk) begin
                if (sys_rst) begin
                    meta[i] <= RST_VAL[i];
                    sync_out[i] <= RST_VAL[i];
                end else begin
                    meta[i] <= async_in[i];
                    sync_out[i] <= meta[i];
                end
            end
        end
    endgenerate
endmodule : scd_sync
`default_nettype wire

// file: test/scd_host_model.sv
`timescale 1ns/10ps
`default_nettype none
// host microcontroller acting as spi master, mode 0
module scd_host_model (
    input wire logic sys_clk,
    output logic spi_sclk,
    output logic spi_cs_n,
    output logic spi_mosi,
    input wire logic spi_miso
);
    // half period in system cycles, 80 ns link period
    localparam int HALF = 5;

    // idle: clock parked low, deselected
    initial begin
        spi_sclk = 1'b0;
        spi_cs_n = 1'b1;
        spi_mosi = 1'b0;
    end

    // wait n falling edges of the system clock
    task automatic wait_n(input int n);
        repeat (n) @(negedge sys_clk);
    endtask : wait_n

    // one frame msb first; fewer than 16 bits makes a cut frame
    task automatic xfer(input logic [15:0] tx, input int nbits, output logic [15:0] rx);
        rx = 16'h0000;
        @(negedge sys_clk);
        spi_cs_n = 1'b0;
        spi_mosi = tx[15];
        for (int i = 0; i < nbits; i++) begin
            wait_n(HALF);
            spi_sclk = 1'b1;
            wait_n(HALF);
            // reply bit still stands here, it is only replaced after this fall
            rx = {rx[14:0], spi_miso};
            spi_sclk = 1'b0;
            // data moves at the falling edge, as the decoder expects
            if (i < 15) begin
                spi_mosi = tx[14-i];
            end
        end
        wait_n(HALF);
        spi_cs_n = 1'b1;
        // released line: never leave the last bit standing
        spi_mosi = ~spi_mosi;
        wait_n(8);
    endtask : xfer
endmodule : scd_host_model
`default_nettype wire

// file: test/scd_spi_decoder_tb.sv
`timescale 1ns/10ps
`default_nettype none
// self-checking bench: frames through the host model, checks on reply and outputs
module scd_spi_decoder_tb
    import scd_pkg::*;
;
    logic sys_clk = 1'b0;
    logic sys_rst = 1'b1;
    wire logic spi_sclk, spi_cs_n, spi_mosi;
    logic spi_miso, spi_miso_oe;
    // byte sources, distinct so a wrong pick shows
    logic [7:0] fs = 8'ha5, es = 8'h3c, di = 8'h5a, fl = 8'h96, fh = 8'h69;
    logic par_en = 1'b0, can_on = 1'b1, norm = 1'b1;
    logic [4:0] frame_addr;
    logic [2:0] monitor_source_sel;
    logic [NUM_SOURCES-1:0] monitor_route;
    logic internal_load_resistor_en, monitor_attenuate;
    logic [15:0] rx; // last reply frame
    int error_cnt = 0;
    int n_tests = 0;

    // 125 MHz system clock
    always #4 sys_clk = ~sys_clk;

    scd_host_model host (.sys_clk(sys_clk), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n),
        .spi_mosi(spi_mosi), .spi_miso(spi_miso));

    scd_spi_decoder uut (.sys_clk(sys_clk), .sys_rst(sys_rst), .spi_sclk(spi_sclk),
        .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi), .spi_miso(spi_miso),
        .spi_miso_oe(spi_miso_oe), .fixed_status(fs), .ext_status(es), .device_info(di),
        .flags_low(fl), .flags_high(fh), .parity_check_en(par_en), .can_supply_on(can_on),
        .normal_mode(norm), .frame_addr(frame_addr), .monitor_source_sel(monitor_source_sel),
        .monitor_route(monitor_route), .internal_load_resistor_en(internal_load_resistor_en),
        .monitor_attenuate(monitor_attenuate));

    // verdict, single exit point
    task automatic finish_test();
        $display("checks %0d errors %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : finish_test

    // compare with case equality so unknowns fail
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // expected monitor outputs for a register value
    function automatic logic [11:0] exp_mon(input logic [7:0] d);
        logic [6:0] r;
        r = (d[7:5] == 3'h0) ? 7'h00 : 7'h01 << (d[7:5] - 3'h1);
        return {d[7:5], r, d[4], d[3] & (d[7:5] == 3'h4 || d[7:5] == 3'h5)};
    endfunction : exp_mon

    // monitor outputs against a register value
    task automatic chk_mon(input logic [7:0] d);
        chk({4'h0, monitor_source_sel, monitor_route, internal_load_resistor_en,
            monitor_attenuate}, {4'h0, exp_mon(d)});
    endtask : chk_mon

    // bit 8 chosen so all sixteen bits hold an odd count of ones
    function automatic logic [15:0] par(input logic [15:0] f);
        return {f[15:9], ~^{f[15:9], f[7:0]}, f[7:0]};
    endfunction : par

    // one frame of n bits through the host
    task automatic send(input logic [15:0] f, input int n);
        host.xfer(f, n, rx);
    endtask : send

    // hang guard, well above the roughly 3800 cycles of traffic
    initial begin
        repeat (30000) @(posedge sys_clk);
        error_cnt++;
        finish_test();
    end

    // main sequence
    initial begin
        repeat (8) @(negedge sys_clk);
        sys_rst = 1'b0;
        repeat (4) @(negedge sys_clk);
        chk({15'h0, spi_miso_oe}, 16'h0000);
        chk_mon(8'h00);
        // write with bit 8 zero, parity off
        send(16'h40ff, 16);
        chk(rx, {fs, es});
        chk_mon(8'hf8);
        // read back and device info, bit 8 one
        send(16'h0100, 16);
        chk(rx, {fs, 8'hf8});
        send(16'h0180, 16);
        chk(rx, {fs, di});
        // flag reads, low then high sub-address
        send(16'he500, 16);
        chk(rx, {fs, fl});
        chk({11'h0, frame_addr}, 16'h0012);
        send(16'he580, 16);
        chk(rx, {fs, fh});
        // reserved code and a write elsewhere leave the monitor alone
        send(16'h80ff, 16);
        chk(rx, {fs, ANSWER_NONE});
        chk_mon(8'hf8);
        send(16'h42aa, 16);
        chk_mon(8'hf8);
        // every source code with attenuation asked for
        for (int s = 0; s < 8; s++) begin
            send({8'h40, s[2:0], 5'h08}, 16);
            chk_mon({s[2:0], 5'h08});
        end
        // cut frame changes nothing
        send(16'h4000, 15);
        chk_mon(8'he8);
        // parity on: bad bit 8 refused, good one taken
        @(negedge sys_clk);
        par_en = 1'b1;
        send(par(16'h4050) ^ 16'h0100, 16);
        chk_mon(8'he8);
        send(par(16'h4050), 16);
        chk_mon(8'h50);
        // read under parity still needs bit 8 one only
        send(16'h0100, 16);
        chk(rx, {fs, 8'h50});
        // leaving normal mode clears the register
        @(negedge sys_clk);
        norm = 1'b0;
        repeat (4) @(negedge sys_clk);
        chk_mon(8'h00);
        norm = 1'b1;
        send(par(16'h40b0), 16);
        chk_mon(8'hb0);
        // supply off: access ignored, register back to zero
        @(negedge sys_clk);
        can_on = 1'b0;
        send(16'h40f0, 16);
        chk_mon(8'h00);
        send(16'h0100, 16);
        chk(rx, {fs, 8'h00});
        finish_test();
    end
endmodule : scd_spi_decoder_tb
`default_nettype wire
